//--- rtl/fca_device.sv
/*
 * Device end: sequence decoding, acceptance against mode and state,
 * status flags, command lock and ready interrupt.
 * Assumes the host keeps writes in order; array timing is a fixed count.
 */
`timescale 1ns/1ns
// How it works
// - code program: E8, 40, 64 words, D0
// - data program: E8, 02, 2 words, D0
// - erase 20,D0; blank check 71,D0
// - multi-block erase is 21 then D0
// - B0 suspend, D0 resume, 50 clear, B3 stop
// - configuration: 40, 08, 8 words, D0
// - data writes carry 16-bit words in order
// - ready drops at start, rises at completion
// - ready interrupt on rise when enabled
// - command lock is OR of error flags
// - mode entry value selects allowed commands
// - bad command locks; suspend in idle is ignored
// - forced stop accepted in every state except the count and data-word steps
// - resume only suspended; clear where allowed
// - erase-suspended: program other blocks or blank check only
// - blank check data mode; config code idle
// - host waits while buffer full in config
// - host enters mode, checks status first
// - unlocked S_PE: ready 0, suspend-ready 1
// - suspended flags follow suspension kind
// - status clear wipes errors and lock
// - forced stop aborts and resets status
module fca_device
    import fca_pkg::*;
#(
    parameter int PROC_CYC = FCA_PROC_CYC,
    parameter int CFG_BUF = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ready_irq_enable_i,
    output logic [15:0] last_word_o,
    fca_link_if.device link
);
    typedef enum logic [3:0] {
        S_IDLE, S_COUNT, S_WORDS, S_CONFIRM, S_PE, S_CFG, S_BLANK, S_STOP,
        S_PSUSP, S_ESUSP, S_PUNDER
    } fca_state_type;

    fca_state_type st_r, st_nxt;
    fca_kind_type kind_r, kind_nxt, dec_kind;
    logic [7:0] left_r, left_nxt;
    logic [15:0] timer_r, timer_nxt;
    logic [FCA_ERR_W-1:0] err_r, err_nxt;
    logic code_access_error_r, code_access_error_nxt, data_access_error_r, data_access_error_nxt;
    logic [FCA_BLOCK_W-1:0] blk_r, blk_nxt, susp_blk_r, susp_blk_nxt;
    logic erase_job_r, erase_job_nxt;
    logic [15:0] word_r, word_nxt;
    logic rdy_q, irq_r, irq_nxt;
    logic [7:0] buf_cnt_r, buf_cnt_nxt;
    logic code_mode, data_mode, locked, ready;

    fca_decoder u_dec (
        .opcode_i(link.cmd_data[7:0]),
        .kind_o(dec_kind)
    );

    assign code_mode = (link.pe_mode_entry_reg == FCA_MODE_CODE);
    assign data_mode = (link.pe_mode_entry_reg == FCA_MODE_DATA);
    assign locked = |err_r;

    always_comb begin
        case (st_r)
            S_PE, S_CFG, S_BLANK, S_STOP, S_PUNDER: ready = 1'b0;
            default: ready = 1'b1;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        kind_nxt = kind_r;
        left_nxt = left_r;
        timer_nxt = timer_r;
        err_nxt = err_r;
        code_access_error_nxt = code_access_error_r;
        data_access_error_nxt = data_access_error_r;
        blk_nxt = blk_r;
        susp_blk_nxt = susp_blk_r;
        erase_job_nxt = erase_job_r;
        word_nxt = word_r;
        buf_cnt_nxt = buf_cnt_r;
        if (timer_r != 16'h0000) begin
            timer_nxt = timer_r - 16'h0001;
        end
        // array completion
        if (timer_r == 16'h0001) begin
            buf_cnt_nxt = 8'h00;
            case (st_r)
                S_PUNDER: st_nxt = S_ESUSP;
                S_PE, S_CFG, S_BLANK, S_STOP: st_nxt = S_IDLE;
                default: st_nxt = st_r;
            endcase
        end
        // the array drains one buffered word per cycle without a write
        if (!link.cmd_wr && buf_cnt_r != 8'h00) begin
            buf_cnt_nxt = buf_cnt_r - 8'h01;
        end
        if (link.cmd_wr) begin
            if (link.pe_mode_entry_reg == FCA_MODE_READ) begin
                st_nxt = st_r; // no command is taken in read mode
            end else if (dec_kind == FCA_K_STOP && st_r != S_COUNT && st_r != S_WORDS) begin
                st_nxt = S_STOP;
                timer_nxt = 16'(PROC_CYC);
                err_nxt = FCA_ERR_RESET;
                code_access_error_nxt = 1'b0;
                data_access_error_nxt = 1'b0;
                erase_job_nxt = 1'b0;
                kind_nxt = FCA_K_STOP;
            end else begin
                case (st_r)
                    S_COUNT: begin
                        left_nxt = link.cmd_data[7:0];
                        st_nxt = S_WORDS;
                        if (kind_r == FCA_K_CFG ? link.cmd_data[7:0] != FCA_N_CFG
                            : (code_mode ? link.cmd_data[7:0] != FCA_N_CODE
                            : link.cmd_data[7:0] != FCA_N_DATA)) begin
                            err_nxt[FCA_ERR_ILGCOM] = 1'b1;
                            st_nxt = S_IDLE;
                        end
                    end
                    S_WORDS: begin
                        word_nxt = link.cmd_data;
                        left_nxt = left_r - 8'h01;
                        if (kind_r == FCA_K_CFG) begin
                            buf_cnt_nxt = buf_cnt_r + 8'h01;
                        end
                        if (left_r == 8'h01) begin
                            st_nxt = S_CONFIRM;
                        end
                    end
                    S_CONFIRM: begin
                        buf_cnt_nxt = 8'h00;
                        if (link.cmd_data[7:0] != FCA_OP_CONFIRM) begin
                            err_nxt[FCA_ERR_ILGCOM] = 1'b1;
                            st_nxt = (kind_r == FCA_K_PROG && erase_job_r) ? S_ESUSP : S_IDLE;
                        end else begin
                            timer_nxt = 16'(PROC_CYC);
                            case (kind_r)
                                FCA_K_CFG: st_nxt = S_CFG;
                                FCA_K_BLANK: st_nxt = S_BLANK;
                                FCA_K_PROG: st_nxt = erase_job_r ? S_PUNDER : S_PE;
                                default: begin
                                    st_nxt = S_PE;
                                    erase_job_nxt = 1'b1;
                                end
                            endcase
                        end
                    end
                    S_PE: begin
                        if (dec_kind == FCA_K_SUSPEND && !locked) begin
                            st_nxt = erase_job_r ? S_ESUSP : S_PSUSP;
                            susp_blk_nxt = blk_r;
                            timer_nxt = 16'h0000;
                        end else begin
                            err_nxt[FCA_ERR_ILGL] = 1'b1;
                        end
                    end
                    S_IDLE, S_PSUSP, S_ESUSP: begin
                        kind_nxt = dec_kind;
                        blk_nxt = link.cmd_block[FCA_BLOCK_W-1:0];
                        case (dec_kind)
                            FCA_K_SUSPEND: begin
                                if (st_r != S_IDLE && !locked) begin
                                    err_nxt[FCA_ERR_ILGL] = 1'b1;
                                end
                            end
                            FCA_K_CLEAR: begin
                                if (locked || st_r == S_IDLE) begin
                                    err_nxt = FCA_ERR_RESET;
                                    code_access_error_nxt = 1'b0;
                                    data_access_error_nxt = 1'b0;
                                end
                            end
                            FCA_K_RESUME: begin
                                if (!locked && st_r != S_IDLE) begin
                                    st_nxt = S_PE;
                                    timer_nxt = 16'(PROC_CYC);
                                    erase_job_nxt = (st_r == S_ESUSP);
                                end else begin
                                    err_nxt[FCA_ERR_ILGL] = 1'b1;
                                end
                            end
                            default: begin
                                if (locked || dec_kind == FCA_K_NONE
                                    || (st_r == S_PSUSP && dec_kind != FCA_K_BLANK)
                                    || (st_r == S_ESUSP && dec_kind != FCA_K_PROG
                                        && dec_kind != FCA_K_BLANK)
                                    || (st_r == S_ESUSP && dec_kind == FCA_K_PROG
                                        && link.cmd_block[FCA_BLOCK_W-1:0] == susp_blk_r)
                                    || (dec_kind == FCA_K_MERASE && !data_mode)
                                    || (dec_kind == FCA_K_BLANK && !data_mode)
                                    || (dec_kind == FCA_K_CFG
                                        && (!code_mode || st_r != S_IDLE))) begin
                                    err_nxt[FCA_ERR_ILGL] = 1'b1;
                                end else if (dec_kind == FCA_K_PROG || dec_kind == FCA_K_CFG) begin
                                    st_nxt = S_COUNT;
                                end else begin
                                    st_nxt = S_CONFIRM;
                                end
                            end
                        endcase
                    end
                    default: err_nxt[FCA_ERR_ILGL] = 1'b1;
                endcase
            end
        end
        irq_nxt = ready && !rdy_q && ready_irq_enable_i;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= S_IDLE;
            kind_r <= FCA_K_NONE;
            left_r <= 8'h00;
            timer_r <= 16'h0000;
            err_r <= FCA_ERR_RESET;
            code_access_error_r <= 1'b0;
            data_access_error_r <= 1'b0;
            blk_r <= '0;
            susp_blk_r <= '0;
            erase_job_r <= 1'b0;
            word_r <= 16'h0000;
            rdy_q <= 1'b1;
            irq_r <= 1'b0;
            buf_cnt_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            kind_r <= kind_nxt;
            left_r <= left_nxt;
            timer_r <= timer_nxt;
            err_r <= err_nxt;
            code_access_error_r <= code_access_error_nxt;
            data_access_error_r <= data_access_error_nxt;
            blk_r <= blk_nxt;
            susp_blk_r <= susp_blk_nxt;
            erase_job_r <= (st_nxt == S_IDLE) ? 1'b0 : erase_job_nxt;
            word_r <= word_nxt;
            rdy_q <= ready;
            irq_r <= irq_nxt;
            buf_cnt_r <= buf_cnt_nxt;
        end
    end

    assign link.sequencer_ready_flag = ready;
    assign link.suspend_ready_flag = (st_r == S_PE) && !locked;
    assign link.erase_suspended_flag = (st_r == S_ESUSP) || (st_r == S_PUNDER);
    assign link.program_suspended_flag = (st_r == S_PSUSP);
    assign link.command_lock_flag = locked;
    assign link.error_flags = err_r;
    assign link.code_access_error = code_access_error_r;
    assign link.data_access_error = data_access_error_r;
    assign link.write_buffer_full_flag = (buf_cnt_r >= 8'(CFG_BUF));
    assign link.ready_irq = irq_r;
    assign last_word_o = word_r;
endmodule : fca_device

//--- rtl/fca_pkg.sv
/*
 * Shared constants for the flash command acceptor: opcodes, word counts,
 * mode entry values and timing counts.
 * Assumes a 25 MHz single clock shared by both ends.
 */
package fca_pkg;
    localparam logic [7:0] FCA_OP_PROG = 8'hE8;
    localparam logic [7:0] FCA_OP_CFG = 8'h40;
    localparam logic [7:0] FCA_OP_ERASE = 8'h20;
    localparam logic [7:0] FCA_OP_MERASE = 8'h21;
    localparam logic [7:0] FCA_OP_BLANK = 8'h71;
    localparam logic [7:0] FCA_OP_SUSPEND = 8'hB0;
    localparam logic [7:0] FCA_OP_CONFIRM = 8'hD0;
    localparam logic [7:0] FCA_OP_CLEAR = 8'h50;
    localparam logic [7:0] FCA_OP_STOP = 8'hB3;
    localparam logic [7:0] FCA_N_CODE = 8'h40;
    localparam logic [7:0] FCA_N_DATA = 8'h02;
    localparam logic [7:0] FCA_N_CFG = 8'h08;
    localparam logic [15:0] FCA_MODE_READ = 16'h0000;
    localparam logic [15:0] FCA_MODE_CODE = 16'h0001;
    localparam logic [15:0] FCA_MODE_DATA = 16'h0080;
    localparam int FCA_ERR_W = 8;
    localparam int FCA_ERR_ILGL = 0;
    localparam int FCA_ERR_ILGCOM = 1;
    localparam logic [7:0] FCA_ERR_RESET = 8'h00;
    localparam int FCA_CLK_MHZ = 25;
    localparam int FCA_PROC_NS = 400;
    localparam int FCA_PROC_CYC = (FCA_PROC_NS * FCA_CLK_MHZ + 999) / 1000;
    localparam int FCA_BLOCK_W = 8;
    typedef enum logic [3:0] {
        FCA_K_NONE, FCA_K_PROG, FCA_K_CFG, FCA_K_ERASE, FCA_K_MERASE,
        FCA_K_BLANK, FCA_K_SUSPEND, FCA_K_RESUME, FCA_K_CLEAR, FCA_K_STOP
    } fca_kind_type;
endpackage : fca_pkg

//--- rtl/fca_link_if.sv
/*
 * Command-issuing link between the processor-side issuer and the device.
 * Assumes both ends share sys_clk_i; one write is one cycle of cmd_wr.
 */
`timescale 1ns/1ns
interface fca_link_if;
    logic cmd_wr;
    logic [15:0] cmd_data;
    logic [15:0] cmd_block;
    logic [15:0] pe_mode_entry_reg;
    logic sequencer_ready_flag;
    logic suspend_ready_flag;
    logic erase_suspended_flag;
    logic program_suspended_flag;
    logic command_lock_flag;
    logic write_buffer_full_flag;
    logic [7:0] error_flags;
    logic code_access_error;
    logic data_access_error;
    logic ready_irq;
    modport device (
        input cmd_wr, cmd_data, cmd_block, pe_mode_entry_reg,
        output sequencer_ready_flag, suspend_ready_flag, erase_suspended_flag,
        output program_suspended_flag, command_lock_flag, write_buffer_full_flag,
        output error_flags, code_access_error, data_access_error, ready_irq
    );
    modport host (
        output cmd_wr, cmd_data, cmd_block, pe_mode_entry_reg,
        input sequencer_ready_flag, suspend_ready_flag, erase_suspended_flag,
        input program_suspended_flag, command_lock_flag, write_buffer_full_flag,
        input error_flags, code_access_error, data_access_error, ready_irq
    );
endinterface : fca_link_if

//--- rtl/fca_decoder.sv
/*
 * Opcode classifier for the first write of a command sequence.
 * Assumes only the low byte of the written word carries the opcode.
 */
`timescale 1ns/1ns
module fca_decoder
    import fca_pkg::*;
(
    input wire logic [7:0] opcode_i,
    output fca_kind_type kind_o
);
    always_comb begin
        case (opcode_i)
            FCA_OP_PROG: kind_o = FCA_K_PROG;
            FCA_OP_CFG: kind_o = FCA_K_CFG;
            FCA_OP_ERASE: kind_o = FCA_K_ERASE;
            FCA_OP_BLANK: kind_o = FCA_K_BLANK;
            FCA_OP_MERASE: kind_o = FCA_K_MERASE;
            FCA_OP_SUSPEND: kind_o = FCA_K_SUSPEND;
            FCA_OP_CONFIRM: kind_o = FCA_K_RESUME;
            FCA_OP_CLEAR: kind_o = FCA_K_CLEAR;
            FCA_OP_STOP: kind_o = FCA_K_STOP;
            default: kind_o = FCA_K_NONE;
        endcase
    end
endmodule : fca_decoder

//--- rtl/fca_host.sv
/*
 * Host end: turns one user request into the ordered write sequence.
 * Assumes the user supplies data words through a per-word handshake.
 */
`timescale 1ns/1ns
module fca_host
    import fca_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] mode_i,
    input wire logic req_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] count_i,
    input wire logic [15:0] block_i,
    input wire logic [15:0] word_i,
    output logic word_take_o,
    output logic busy_o,
    fca_link_if.host link
);
    typedef enum logic [2:0] {H_IDLE, H_COUNT, H_WORDS, H_CONFIRM} fca_hstate_type;
    fca_hstate_type st_r, st_nxt;
    logic [7:0] left_r, left_nxt, cnt_r, cnt_nxt;
    logic [15:0] blk_r, blk_nxt;
    logic wr, hold;

    // a queued write waits while the configuration buffer is full
    assign hold = link.write_buffer_full_flag;

    always_comb begin
        st_nxt = st_r;
        left_nxt = left_r;
        cnt_nxt = cnt_r;
        blk_nxt = blk_r;
        wr = 1'b0;
        link.cmd_data = 16'h0000;
        word_take_o = 1'b0;
        case (st_r)
            H_IDLE: begin
                // write buffer must not be full and the mode set before issuing
                if (req_i && !hold && mode_i != FCA_MODE_READ) begin
                    wr = 1'b1;
                    link.cmd_data = {8'h00, opcode_i};
                    blk_nxt = block_i;
                    cnt_nxt = count_i;
                    if (opcode_i == FCA_OP_PROG || opcode_i == FCA_OP_CFG) begin
                        st_nxt = H_COUNT;
                    end else if (opcode_i == FCA_OP_ERASE || opcode_i == FCA_OP_MERASE
                                 || opcode_i == FCA_OP_BLANK) begin
                        st_nxt = H_CONFIRM;
                    end
                end
            end
            H_COUNT: if (!hold) begin
                wr = 1'b1;
                link.cmd_data = {8'h00, cnt_r};
                left_nxt = cnt_r;
                st_nxt = H_WORDS;
            end
            H_WORDS: if (!hold) begin
                wr = 1'b1;
                link.cmd_data = word_i;
                word_take_o = 1'b1;
                left_nxt = left_r - 8'h01;
                if (left_r == 8'h01) begin
                    st_nxt = H_CONFIRM;
                end
            end
            H_CONFIRM: if (!hold) begin
                wr = 1'b1;
                link.cmd_data = {8'h00, FCA_OP_CONFIRM};
                st_nxt = H_IDLE;
            end
            default: st_nxt = H_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= H_IDLE;
            left_r <= 8'h00;
            cnt_r <= 8'h00;
            blk_r <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            left_r <= left_nxt;
            cnt_r <= cnt_nxt;
            blk_r <= blk_nxt;
        end
    end

    assign link.cmd_wr = wr;
    assign link.cmd_block = (st_r == H_IDLE) ? block_i : blk_r;
    assign link.pe_mode_entry_reg = mode_i;
    assign busy_o = (st_r != H_IDLE);
endmodule : fca_host

//--- verification/fca_assertions.sv
/*
 * Concurrent checks on the command link joining the host and device ends.
 * Assumes one clock and an asynchronous active-high reset for both ends.
 */
`timescale 1ns/1ns
module fca_assertions
    import fca_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ready_irq_enable_i,
    input wire logic cmd_wr,
    input wire logic [15:0] cmd_data,
    input wire logic [15:0] pe_mode_entry_reg,
    input wire logic sequencer_ready_flag,
    input wire logic suspend_ready_flag,
    input wire logic erase_suspended_flag,
    input wire logic program_suspended_flag,
    input wire logic command_lock_flag,
    input wire logic [7:0] error_flags,
    input wire logic ready_irq
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    AST_LOCK_OR: assert property (command_lock_flag == (|error_flags))
        else $error("lock flag differs from the OR of the error flags");
    AST_IRQ_ON_RISE: assert property ($rose(sequencer_ready_flag) && ready_irq_enable_i
        |=> ready_irq) else $error("no ready interrupt after ready rose");
    // the ready level is not tied at the pulse itself: a new command may drop it there
    AST_IRQ_CAUSE: assert property (ready_irq
        |-> $past(sequencer_ready_flag) && !$past(sequencer_ready_flag, 2))
        else $error("ready interrupt without a ready rise");
    AST_SUSPEND_READY_FLAG_ONLY_BUSY: assert property (suspend_ready_flag
        |-> !sequencer_ready_flag && !erase_suspended_flag && !program_suspended_flag)
        else $error("suspend ready outside processing");
    AST_READY_RETURNS: assert property ($fell(sequencer_ready_flag)
        |-> ##[1:200] sequencer_ready_flag) else $error("ready did not return");
    AST_PROGRAM_SUSPENDED_FLAG_READY: assert property (program_suspended_flag
        |-> sequencer_ready_flag && !erase_suspended_flag)
        else $error("program suspended with wrong flags");
    AST_READ_MODE_QUIET: assert property (pe_mode_entry_reg == FCA_MODE_READ |-> !cmd_wr)
        else $error("command written in read mode");
    AST_CLEAR_WIPES: assert property (cmd_wr && cmd_data[7:0] == FCA_OP_CLEAR
        && sequencer_ready_flag && pe_mode_entry_reg != FCA_MODE_READ
        |=> error_flags == FCA_ERR_RESET) else $error("status clear left errors");
    AST_STOP_RESETS: assert property (cmd_wr && cmd_data[7:0] == FCA_OP_STOP
        && pe_mode_entry_reg != FCA_MODE_READ |=> error_flags == FCA_ERR_RESET
        && !sequencer_ready_flag && !erase_suspended_flag && !program_suspended_flag)
        else $error("forced stop did not reset status");
endmodule : fca_assertions

//--- verification/fca_tb.sv
/*
 * Bench: host and device ends joined by the link, driven from the host user side.
 * Assumes the device processing count is left at its package default of ten cycles.
 */
`timescale 1ns/1ns
module fca_tb;
    import fca_pkg::*;
    localparam int PROC = FCA_PROC_CYC;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic irq_en = 1'b0;
    logic [15:0] mode_i = 16'h0000;
    logic req_i = 1'b0;
    logic [7:0] opcode_i = 8'h00;
    logic [7:0] count_i = 8'h00;
    logic [15:0] block_i = 16'h0000;
    logic [15:0] word_i = 16'h0000;
    logic word_take_o;
    logic busy_o;
    logic [15:0] last_word_o;
    int error_cnt = 0;
    int n_compared = 0;
    int run = 0;
    int low_len = 0;
    int irq_cnt = 0;
    fca_link_if link_if ();
    fca_host u_fca_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .mode_i(mode_i),
        .req_i(req_i), .opcode_i(opcode_i), .count_i(count_i), .block_i(block_i),
        .word_i(word_i), .word_take_o(word_take_o), .busy_o(busy_o), .link(link_if.host));
    fca_device u_fca_device (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .ready_irq_enable_i(irq_en), .last_word_o(last_word_o), .link(link_if.device));
    fca_assertions u_fca_assertions (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .ready_irq_enable_i(irq_en), .cmd_wr(link_if.cmd_wr), .cmd_data(link_if.cmd_data),
        .pe_mode_entry_reg(link_if.pe_mode_entry_reg),
        .sequencer_ready_flag(link_if.sequencer_ready_flag),
        .suspend_ready_flag(link_if.suspend_ready_flag),
        .erase_suspended_flag(link_if.erase_suspended_flag),
        .program_suspended_flag(link_if.program_suspended_flag),
        .command_lock_flag(link_if.command_lock_flag), .error_flags(link_if.error_flags),
        .ready_irq(link_if.ready_irq));
    initial begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    // ready-low run length and interrupt count, sampled before each edge lands
    always @(posedge sys_clk_i) begin
        if (link_if.ready_irq === 1'b1) begin
            irq_cnt++;
        end
        if (link_if.sequencer_ready_flag === 1'b0) begin
            run++;
        end else if (run != 0) begin
            low_len = run;
            run = 0;
        end
        if (word_take_o === 1'b1) begin
            word_i <= word_i + 16'h0001;
        end
    end
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chkb(input string what, input logic exp, input logic got);
        chk(what, {15'h0000, exp}, {15'h0000, got});
    endtask : chkb
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick
    task automatic wait_for(input string what, input logic lvl, ref logic sig);
        int t;
        for (t = 0; t < 400 && sig !== lvl; t++) begin
            tick(1);
        end
        if (sig !== lvl) begin
            error_cnt++;
            $display("BAD %s wait expected %b seen %b", what, lvl, sig);
            print_verdict();
        end
    endtask : wait_for
    task automatic do_cmd(input logic [15:0] m, input logic [7:0] op, input logic [7:0] n,
            input logic [15:0] blk);
        tick(1);
        mode_i <= m;
        opcode_i <= op;
        count_i <= n;
        block_i <= blk;
        word_i <= 16'hA000;
        req_i <= 1'b1;
        wait_for("write", 1'b1, link_if.cmd_wr);
        req_i <= 1'b0;
        tick(1);
        wait_for("busy", 1'b0, busy_o);
    endtask : do_cmd
    task automatic settle;
        tick(2);
        wait_for("ready", 1'b1, link_if.sequencer_ready_flag);
        tick(3);
    endtask : settle
    task automatic issue(input logic [15:0] m, input logic [7:0] op, input logic [7:0] n,
            input logic [15:0] blk, input logic lock);
        do_cmd(m, op, n, blk);
        settle();
        chkb("lock", lock, link_if.command_lock_flag);
    endtask : issue
    task automatic clear(input logic [15:0] m);
        issue(m, FCA_OP_CLEAR, 8'h00, 16'h0000, 1'b0);
        chk("errors", {8'h00, FCA_ERR_RESET}, {8'h00, link_if.error_flags});
    endtask : clear
    task automatic fin(input string name);
        $display("test %s done", name);
    endtask : fin
    initial begin
        tick(16);
        rst_i <= 1'b0;
        tick(1);
        chkb("ready", 1'b1, link_if.sequencer_ready_flag);
        chkb("lock", 1'b0, link_if.command_lock_flag);
        req_i <= 1'b1;
        tick(6);
        chkb("busy", 1'b0, busy_o);
        req_i <= 1'b0;
        fin("reset and read mode");
        irq_en <= 1'b1;
        issue(FCA_MODE_CODE, FCA_OP_ERASE, 8'h00, 16'h0001, 1'b0);
        chk("low cycles", PROC[15:0], low_len[15:0]);
        chk("irq count", 16'h0001, irq_cnt[15:0]);
        irq_en <= 1'b0;
        issue(FCA_MODE_CODE, FCA_OP_PROG, FCA_N_CODE, 16'h0002, 1'b0);
        chk("last word", 16'hA03F, last_word_o);
        chk("irq count", 16'h0001, irq_cnt[15:0]);
        issue(FCA_MODE_CODE, FCA_OP_CFG, FCA_N_CFG, 16'h0000, 1'b0);
        chk("last word", 16'hA007, last_word_o);
        fin("code mode");
        issue(FCA_MODE_CODE, FCA_OP_SUSPEND, 8'h00, 16'h0000, 1'b0);
        issue(FCA_MODE_CODE, FCA_OP_CONFIRM, 8'h00, 16'h0000, 1'b1);
        chkb("illegal", 1'b1, link_if.error_flags[FCA_ERR_ILGL]);
        clear(FCA_MODE_CODE);
        issue(FCA_MODE_CODE, FCA_OP_PROG, FCA_N_DATA, 16'h0002, 1'b1);
        chkb("bad sequence", 1'b1, link_if.error_flags[FCA_ERR_ILGCOM]);
        issue(FCA_MODE_CODE, FCA_OP_STOP, 8'h00, 16'h0000, 1'b0);
        chk("low cycles", PROC[15:0], low_len[15:0]);
        fin("refusals");
        issue(FCA_MODE_DATA, FCA_OP_BLANK, 8'h00, 16'h0004, 1'b0);
        issue(FCA_MODE_DATA, FCA_OP_MERASE, 8'h00, 16'h0004, 1'b0);
        issue(FCA_MODE_DATA, FCA_OP_PROG, FCA_N_DATA, 16'h0004, 1'b0);
        chk("last word", 16'hA001, last_word_o);
        issue(FCA_MODE_DATA, FCA_OP_CFG, FCA_N_CFG, 16'h0000, 1'b1);
        clear(FCA_MODE_DATA);
        issue(FCA_MODE_CODE, FCA_OP_BLANK, 8'h00, 16'h0000, 1'b1);
        clear(FCA_MODE_CODE);
        issue(FCA_MODE_CODE, FCA_OP_MERASE, 8'h00, 16'h0000, 1'b1);
        clear(FCA_MODE_CODE);
        fin("mode table");
        // suspend must land inside the erase, so no settling between the two
        do_cmd(FCA_MODE_DATA, FCA_OP_ERASE, 8'h00, 16'h0001);
        do_cmd(FCA_MODE_DATA, FCA_OP_SUSPEND, 8'h00, 16'h0000);
        settle();
        chkb("erase suspended", 1'b1, link_if.erase_suspended_flag);
        chkb("suspend ready", 1'b0, link_if.suspend_ready_flag);
        do_cmd(FCA_MODE_DATA, FCA_OP_PROG, FCA_N_DATA, 16'h0002);
        tick(2);
        chkb("ready", 1'b0, link_if.sequencer_ready_flag);
        chkb("erase suspended", 1'b1, link_if.erase_suspended_flag);
        settle();
        chkb("lock", 1'b0, link_if.command_lock_flag);
        issue(FCA_MODE_DATA, FCA_OP_ERASE, 8'h00, 16'h0003, 1'b1);
        clear(FCA_MODE_DATA);
        issue(FCA_MODE_DATA, FCA_OP_PROG, FCA_N_DATA, 16'h0001, 1'b1);
        clear(FCA_MODE_DATA);
        chkb("erase suspended", 1'b1, link_if.erase_suspended_flag);
        issue(FCA_MODE_DATA, FCA_OP_CONFIRM, 8'h00, 16'h0000, 1'b0);
        chkb("erase suspended", 1'b0, link_if.erase_suspended_flag);
        fin("suspend and resume");
        do_cmd(FCA_MODE_CODE, FCA_OP_PROG, FCA_N_CODE, 16'h0002);
        do_cmd(FCA_MODE_CODE, FCA_OP_SUSPEND, 8'h00, 16'h0000);
        settle();
        chkb("program suspended", 1'b1, link_if.program_suspended_flag);
        issue(FCA_MODE_CODE, FCA_OP_CONFIRM, 8'h00, 16'h0000, 1'b0);
        chkb("program suspended", 1'b0, link_if.program_suspended_flag);
        fin("program suspend");
        do_cmd(FCA_MODE_CODE, FCA_OP_ERASE, 8'h00, 16'h0001);
        issue(FCA_MODE_CODE, FCA_OP_STOP, 8'h00, 16'h0000, 1'b0);
        fin("stop while busy");
        print_verdict();
    end
endmodule : fca_tb
